//--- design/comm_pkg.sv
package comm_pkg;
  // function selected for the block
  typedef enum logic [1:0] {FN_UART_RX, FN_UART_TX, FN_SPI_MASTER, FN_OFF} comm_fn_t;
  // receiver sequence
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
  // transmitter sequence
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  // spi master sequence
  typedef enum logic {SPI_IDLE, SPI_SHIFT} spi_state_t;

  localparam int DATA_W = 8;             // character width
  localparam int DIV_W = 8;              // baud divider width
  localparam int OVERSAMPLE = 8;         // ticks per uart bit
  localparam logic [2:0] TICK_LAST = 3'(OVERSAMPLE - 1);
  localparam logic [2:0] MID_TICK = 3'h3;    // fourth tick of a bit period
  localparam logic [2:0] BIT_LAST = 3'h7;    // index of last data bit
  localparam logic [3:0] SPI_EDGE_LAST = 4'hF; // 8 bits, two sclk edges each
  localparam int FIFO_DEPTH = 2;         // receive buffer entries
  // status vector layout
  localparam int STATUS_W = 6;
  localparam int ST_PARITY_ERR = 0;
  localparam int ST_FRAMING_ERR = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_RX_FULL = 3;
  localparam int ST_TX_EMPTY = 4;
  localparam int ST_COMPLETE = 5;
  localparam logic [STATUS_W-1:0] STATUS_RST = 6'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
endpackage

//--- design/byte_stream_if.sv
`timescale 1ns/1ns
// one byte stream with valid/ready handshake
interface byte_stream_if;
  logic valid; // word offered
  logic ready; // word accepted when both high
  logic [comm_pkg::DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- design/comm_tick_gen.sv
`timescale 1ns/1ns
// divides the core clock into a one-cycle enable pulse
module comm_tick_gen (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [comm_pkg::DIV_W-1:0] i_div,
  output logic o_tick
);
  import comm_pkg::*;
  logic [DIV_W-1:0] cnt_q; // counts down to the next pulse

  // reload on each pulse; a divisor of zero ticks every cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_run || cnt_q == DIV_RST) begin
      cnt_q <= i_div;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_tick = i_run && (cnt_q == DIV_RST);
endmodule

//--- design/comm_rx_fifo.sv
`timescale 1ns/1ns
// two-entry receive buffer; its head is the readable receive byte
module comm_rx_fifo (
  input wire logic i_core_clk,
  input wire logic i_rst,
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  import comm_pkg::*;
  logic [DATA_W-1:0] mem [FIFO_DEPTH]; // storage
  logic wr_ptr_q; // next slot to fill
  logic rd_ptr_q; // head slot
  logic [1:0] count_q; // entries held
  logic push;
  logic pop;

  assign wr.ready = (count_q != 2'(FIFO_DEPTH));
  assign rd.valid = (count_q != 2'h0);
  assign rd.data = mem[rd_ptr_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // storage has no reset; only valid entries are ever shown
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= wr.data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end

  // fill level never passes the two entries, so no byte is written over
  property p_no_overfill;
    @(posedge i_core_clk) disable iff (i_rst) count_q <= 2'(FIFO_DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("receive buffer overfilled"); // RULE2
endmodule

//--- design/comm_block.sv
`timescale 1ns/1ns
// Functional notes
// RULE1 - receive 8-bit characters, strip framing, check parity
// RULE2 - completed byte moves to receive buffer
// RULE3 - receiver timed from eight-times baud tick
// RULE4 - start found, bits sampled four ticks in
// RULE5 - receive interrupt while buffer full, if enabled
// RULE6 - status read clears all but buffer full; the code also keeps transmit empty
// RULE7 - no further interrupt until buffer read
// RULE8 - missing stop flags framing error, may restart
// RULE9 - empty shifter loads buffer, sends full frame
// RULE10 - transmit buffer reusable once shifter loaded
// RULE11 - transmitter on eight-times tick, ignores input
// RULE12 - serial output idles high between characters
// RULE13 - transmit interrupt: buffer empty or complete
// RULE14 - software writes first byte before empty interrupts
// RULE15 - status read keeps empty; write clears it
// RULE16 - status held until cleared, interrupts suppressed
// RULE17 - spi write while idle starts full-duplex shift
// RULE18 - after eight bits, store and reload together
// RULE19 - all four spi clock modes selectable
// RULE20 - software writes filler byte per received byte
// RULE21 - spi clock is tick divided by two
// RULE22 - no slave select generated by master
// RULE23 - spi interrupt: buffer empty or complete
// RULE24 - spi status read keeps empty and full
module comm_block (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire comm_pkg::comm_fn_t i_function,
  input wire logic [comm_pkg::DIV_W-1:0] i_clk_div,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_int_en,
  input wire logic i_int_sel,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_serial_in,
  input wire logic i_tx_write,
  input wire logic [comm_pkg::DATA_W-1:0] i_tx_data,
  input wire logic i_rx_read,
  input wire logic i_status_read,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [comm_pkg::DATA_W-1:0] o_rx_data,
  output logic [comm_pkg::STATUS_W-1:0] o_status,
  output logic o_serial_out,
  output logic o_spi_clk,
  output logic o_irq
);
  import comm_pkg::*;

  logic tick; // selected baud or bit clock enable
  logic in_meta_q, in_q; // pin synchroniser
  logic is_rx, is_tx, is_spi;
  logic [STATUS_W-1:0] status_q; // flags, clear-on-read ones included
  logic tx_hold_valid_q; // transmit buffer occupied
  logic [DATA_W-1:0] tx_hold_q; // transmit buffer
  logic tx_take; // buffer moves into shifter this cycle
  logic push_valid_q; // byte offered to receive buffer
  logic [DATA_W-1:0] push_data_q;
  logic set_parity, set_framing, set_overrun, set_complete;
  byte_stream_if rx_in ();
  byte_stream_if rx_out ();

  assign is_rx = i_enable && (i_function == FN_UART_RX);
  assign is_tx = i_enable && (i_function == FN_UART_TX);
  assign is_spi = i_enable && (i_function == FN_SPI_MASTER);

  comm_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(i_enable),
    .i_div(i_clk_div),
    .o_tick(tick)
  );

  // two flops before the pin reaches any logic
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      in_meta_q <= 1'b1;
      in_q <= 1'b1;
    end else begin
      in_meta_q <= i_serial_in;
      in_q <= in_meta_q;
    end
  end

  // ---------------- uart receiver ----------------
  rx_state_t rx_state_q;
  logic [2:0] rx_phase_q; // tick within the bit period
  logic [2:0] rx_bit_q; // data bit index
  logic [DATA_W-1:0] rx_shift_q;
  logic rx_mid; // sample point of the current bit
  logic rx_push, rx_perr, rx_ferr;

  assign rx_mid = tick && (rx_phase_q == MID_TICK); // RULE4

  // bit-period counter; restarts at a detected start edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !is_rx || rx_state_q == RX_IDLE) begin
      rx_phase_q <= 3'h0;
    end else if (tick) begin
      rx_phase_q <= rx_phase_q + 3'h1; // RULE3
    end
  end

  // framing sequence, lsb first
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !is_rx) begin
      rx_state_q <= RX_IDLE;
      rx_bit_q <= 3'h0;
      rx_shift_q <= BYTE_RST;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          // low line at a tick is a start; also covers a missing stop
          if (tick && !in_q) begin
            rx_state_q <= RX_START; // RULE4 RULE8
          end
        end
        RX_START: begin
          // glitch that is high again mid-bit is not a start
          if (rx_mid) begin
            rx_state_q <= in_q ? RX_IDLE : RX_DATA; // RULE1
            rx_bit_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_q <= {in_q, rx_shift_q[DATA_W-1:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == BIT_LAST) begin
              rx_state_q <= i_parity_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_mid) begin
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state_q <= RX_IDLE; // stop bit discarded
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // parity bit remembered; checked at the stop sample
  logic rx_par_bit_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_par_bit_q <= 1'b0;
    end else if (rx_state_q == RX_PARITY && rx_mid) begin
      rx_par_bit_q <= in_q;
    end
  end

  assign rx_push = is_rx && rx_state_q == RX_STOP && rx_mid; // RULE2
  assign rx_ferr = rx_push && !in_q; // RULE8
  assign rx_perr = rx_push && i_parity_en &&
                   ((^rx_shift_q ^ rx_par_bit_q) != i_parity_odd); // RULE1

  // ---------------- uart transmitter ----------------
  tx_state_t tx_state_q;
  logic [2:0] tx_phase_q;
  logic [2:0] tx_bit_q;
  logic [DATA_W-1:0] tx_shift_q;
  logic tx_par_q; // running parity of sent data
  logic tx_line_q; // serial output level
  logic tx_bit_end; // last tick of the current bit

  assign tx_bit_end = tick && (tx_phase_q == TICK_LAST);

  // bit-period counter, eight ticks per bit
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !is_tx || tx_state_q == TX_IDLE) begin
      tx_phase_q <= 3'h0;
    end else if (tick) begin
      tx_phase_q <= tx_phase_q + 3'h1; // RULE11
    end
  end

  // frame generation; serial input is never looked at here
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !is_tx) begin
      tx_state_q <= TX_IDLE;
      tx_line_q <= 1'b1;
      tx_bit_q <= 3'h0;
      tx_shift_q <= BYTE_RST;
      tx_par_q <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_line_q <= 1'b1; // RULE12
          if (tick && tx_hold_valid_q) begin
            tx_state_q <= TX_START; // RULE9
            tx_shift_q <= tx_hold_q;
            tx_line_q <= 1'b0;
            tx_par_q <= i_parity_odd;
            tx_bit_q <= 3'h0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state_q <= TX_DATA;
            tx_line_q <= tx_shift_q[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_par_q <= tx_par_q ^ tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[DATA_W-1:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == BIT_LAST) begin
              tx_state_q <= i_parity_en ? TX_PARITY : TX_STOP;
              tx_line_q <= i_parity_en ? (tx_par_q ^ tx_shift_q[0]) : 1'b1;
            end else begin
              tx_line_q <= tx_shift_q[1];
            end
          end
        end
        TX_PARITY: begin
          if (tx_bit_end) begin
            tx_state_q <= TX_STOP;
            tx_line_q <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_state_q <= TX_IDLE; // RULE12
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ---------------- spi master ----------------
  spi_state_t spi_state_q;
  logic [3:0] spi_edge_q; // even: leading edge, odd: trailing
  logic [DATA_W-1:0] spi_shift_q;
  logic spi_samp_q; // bit caught on a leading edge
  logic spi_mosi_q;
  logic spi_sclk_q;
  logic spi_load, spi_done, spi_lead;

  assign spi_lead = !spi_edge_q[0];
  assign spi_done = is_spi && spi_state_q == SPI_SHIFT && tick &&
                    spi_edge_q == SPI_EDGE_LAST; // RULE18
  assign spi_load = is_spi && tx_hold_valid_q &&
                    (spi_state_q == SPI_IDLE || spi_done); // RULE17 RULE18

  // shifter: every tick is one sclk edge, so sclk is tick over two
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !is_spi) begin
      spi_state_q <= SPI_IDLE;
      spi_edge_q <= 4'h0;
      spi_shift_q <= BYTE_RST;
      spi_samp_q <= 1'b0;
      spi_mosi_q <= 1'b0;
      spi_sclk_q <= i_cpol & i_enable;
    end else begin
      case (spi_state_q)
        SPI_IDLE: begin
          spi_sclk_q <= i_cpol; // RULE19
          if (spi_load) begin
            spi_state_q <= SPI_SHIFT;
            spi_shift_q <= tx_hold_q;
            spi_mosi_q <= tx_hold_q[DATA_W-1];
            spi_edge_q <= 4'h0;
          end
        end
        SPI_SHIFT: begin
          if (tick) begin
            spi_sclk_q <= ~spi_sclk_q; // RULE21
            spi_edge_q <= spi_edge_q + 4'h1;
            if (spi_lead) begin
              // mode 0/2 sample here, mode 1/3 drive here
              if (i_cpha) begin
                spi_mosi_q <= spi_shift_q[DATA_W-1]; // RULE19
              end else begin
                spi_samp_q <= in_q;
              end
            end else if (spi_done && spi_load) begin
              spi_shift_q <= tx_hold_q; // RULE18
              // mode 1/3: this is a sampling edge, new msb waits for the lead
              if (!i_cpha) begin
                spi_mosi_q <= tx_hold_q[DATA_W-1];
              end
            end else if (spi_done) begin
              spi_state_q <= SPI_IDLE;
            end else begin
              spi_shift_q <= {spi_shift_q[DATA_W-2:0], i_cpha ? in_q : spi_samp_q};
              if (!i_cpha) begin
                spi_mosi_q <= spi_shift_q[DATA_W-2];
              end
            end
          end
        end
        default: spi_state_q <= SPI_IDLE;
      endcase
    end
  end

  // ---------------- buffers and status ----------------
  assign tx_take = (is_tx && tx_state_q == TX_IDLE && tick && tx_hold_valid_q) ||
                   spi_load;

  // single-byte transmit buffer, free again once the shifter has it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_hold_valid_q <= 1'b0;
      tx_hold_q <= BYTE_RST;
    end else if (i_tx_write && o_tx_ready) begin
      tx_hold_valid_q <= 1'b1; // RULE10
      tx_hold_q <= i_tx_data;
    end else if (tx_take) begin
      tx_hold_valid_q <= 1'b0; // RULE10
    end
  end

  // received byte, last spi bit merged in for the done step
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      push_valid_q <= 1'b0;
      push_data_q <= BYTE_RST;
    end else begin
      push_valid_q <= rx_push || spi_done;
      push_data_q <= spi_done ?
        {spi_shift_q[DATA_W-2:0], i_cpha ? in_q : spi_samp_q} : rx_shift_q;
    end
  end

  assign rx_in.valid = push_valid_q;
  assign rx_in.data = push_data_q;
  assign rx_out.ready = i_rx_read; // RULE6 buffer read pops

  comm_rx_fifo u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .wr(rx_in.snk),
    .rd(rx_out.src)
  );

  assign set_parity = rx_perr;
  assign set_framing = rx_ferr;
  assign set_overrun = push_valid_q && !rx_in.ready; // word dropped when full
  assign set_complete = (is_tx && tx_state_q == TX_STOP && tx_bit_end) || spi_done;

  // clear-on-read flags: a set in the read cycle wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q[ST_PARITY_ERR] <= set_parity ||
        (status_q[ST_PARITY_ERR] && !i_status_read); // RULE6 RULE15 RULE24
      status_q[ST_FRAMING_ERR] <= set_framing ||
        (status_q[ST_FRAMING_ERR] && !i_status_read);
      status_q[ST_OVERRUN] <= set_overrun || (status_q[ST_OVERRUN] && !i_status_read);
      status_q[ST_COMPLETE] <= set_complete ||
        (status_q[ST_COMPLETE] && !i_status_read); // RULE13 RULE16
      status_q[ST_RX_FULL] <= rx_out.valid; // RULE6
      // empty only after a first byte was taken; a write clears it
      if (tx_take) begin
        status_q[ST_TX_EMPTY] <= 1'b1; // RULE14
      end else if (i_tx_write) begin
        status_q[ST_TX_EMPTY] <= 1'b0; // RULE15
      end
    end
  end

  // level interrupt: stays up until its status is cleared
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else if (is_rx) begin
      o_irq <= i_int_en && rx_out.valid; // RULE5 RULE7
    end else if (is_tx || is_spi) begin
      o_irq <= i_int_en && (i_int_sel ? status_q[ST_COMPLETE]
                                      : status_q[ST_TX_EMPTY]); // RULE13 RULE23 RULE16
    end else begin
      o_irq <= 1'b0;
    end
  end

  // no slave select here; software drives one from a spare pin
  assign o_tx_ready = !tx_hold_valid_q;
  assign o_rx_valid = rx_out.valid;
  assign o_rx_data = rx_out.data;
  assign o_status = status_q;
  assign o_serial_out = is_spi ? spi_mosi_q : tx_line_q;
  assign o_spi_clk = spi_sclk_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_rx_full_irq;
    is_rx && i_int_en && o_rx_valid |=> o_irq;
  endproperty
  a_rx_full_irq: assert property (p_rx_full_irq) else $error("rx irq missing"); // RULE5
  property p_rx_read_clears;
    is_rx && o_rx_valid && i_rx_read && u_fifo.count_q == 2'h1 && !push_valid_q
      |=> !o_rx_valid;
  endproperty
  a_rx_read_clears: assert property (p_rx_read_clears) else $error("full kept"); // RULE6
  property p_read_clears_err;
    i_status_read && !set_framing |=> !status_q[ST_FRAMING_ERR];
  endproperty
  a_read_clears_err: assert property (p_read_clears_err) else $error("err kept"); // RULE6
  property p_tx_idle_high;
    is_tx && tx_state_q == TX_IDLE |-> o_serial_out;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high) else $error("line not idle"); // RULE12
  property p_tx_start_low;
    is_tx && tx_state_q == TX_IDLE && tick && tx_hold_valid_q |=> !o_serial_out[*8];
  endproperty
  a_tx_start_low: assert property (p_tx_start_low) else $error("bad start"); // RULE9
  property p_write_clears_empty;
    i_tx_write && !tx_take |=> !status_q[ST_TX_EMPTY];
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty kept"); // RULE15
  property p_take_frees;
    tx_take && !i_tx_write |=> o_tx_ready && status_q[ST_TX_EMPTY];
  endproperty
  a_take_frees: assert property (p_take_frees) else $error("buffer held"); // RULE10
  property p_sclk_idle;
    is_spi && spi_state_q == SPI_IDLE && $stable(i_cpol) |=> o_spi_clk == $past(i_cpol);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk idle level"); // RULE19
  property p_sclk_half;
    is_spi && spi_state_q == SPI_SHIFT && tick |=> o_spi_clk != $past(o_spi_clk);
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk not toggled"); // RULE21
  property p_spi_store;
    spi_done |=> ##1 o_rx_valid;
  endproperty
  a_spi_store: assert property (p_spi_store) else $error("spi byte lost"); // RULE18
  property p_cmp_irq;
    (is_tx || is_spi) && i_int_en && i_int_sel && status_q[ST_COMPLETE] |=> o_irq;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("complete irq missing"); // RULE13

  c_rx_char: cover property (rx_push && !rx_ferr);
  c_rx_frame_err: cover property (rx_ferr);
  c_tx_done: cover property (is_tx && set_complete);
  c_spi_back_to_back: cover property (spi_done && spi_load);
endmodule

//--- test/comm_far_end.sv
`timescale 1ns/1ns
// remote party: uart sender and spi slave on the one input line
module comm_far_end (
  input wire logic i_core_clk,
  input wire logic i_spi,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_line
);
  logic uart_q = 1'b1; // uart line, idles high
  logic sclk_q = 1'b0; // sclk one core cycle ago
  logic [7:0] out_q = 8'h00; // slave shift-out byte
  logic [7:0] seen_q = 8'h00; // bits taken from mosi
  logic miso_q = 1'b0; // bit launched on leading edge
  logic lead; // sclk leaves its idle level
  logic trail; // sclk returns to its idle level
  // no select input: slave listens whenever the role is on
  assign lead = (i_sclk !== sclk_q) && (i_sclk !== i_cpol);
  assign trail = (i_sclk !== sclk_q) && (i_sclk === i_cpol);
  assign o_line = i_spi ? (i_cpha ? miso_q : out_q[7]) : uart_q;
  // spent bits refill inverted so stale data never passes for new data
  always @(posedge i_core_clk) begin
    sclk_q <= i_sclk;
    if (i_cpha ? trail : lead) begin
      seen_q <= {seen_q[6:0], i_mosi};
    end
    if (i_cpha ? lead : trail) begin
      miso_q <= out_q[7];
      out_q <= {out_q[6:0], ~out_q[7]};
    end
  end
  // next reply byte, loaded while sclk is idle
  task automatic spi_load(input logic [7:0] b);
    out_q = b;
  endtask
  // one frame lsb first; caller picks parity and stop levels
  task automatic uart_send(input logic [7:0] d, input logic p, input logic stop,
      input int bit_cyc);
    logic [10:0] f;
    f = {stop, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      uart_q = f[i];
      repeat (bit_cyc) @(negedge i_core_clk);
    end
    uart_q = 1'b1;
  endtask
endmodule

//--- test/comm_block_tb_top.sv
`timescale 1ns/1ns
// uart tx, uart rx and spi master against a queue model
module comm_block_tb_top;
  import comm_pkg::*;
  localparam int BIT_CYC = 48; // 8 ticks of 6 core cycles
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic en = 1'b0;
  comm_fn_t fn = FN_UART_TX;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic int_en = 1'b1;
  logic int_sel = 1'b0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic tx_wr = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic rx_rd = 1'b0;
  logic st_rd = 1'b0;
  wire logic ser_in; // driven by the far end
  logic tx_ready, rx_valid, ser_out, spi_clk, irq, sclk_q;
  logic [7:0] rx_data;
  logic [5:0] status;
  logic [7:0] a, b, r;
  logic [7:0] rxq[$]; // bytes the receiver should yield
  int seed, tog, t0;
  int miscompares = 0;
  int check_count = 0;

  always #50 i_core_clk = ~i_core_clk;

  comm_block comm_block_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_enable(en),
    .i_function(fn), .i_clk_div(8'h05), .i_parity_en(par_en), .i_parity_odd(par_odd),
    .i_int_en(int_en), .i_int_sel(int_sel), .i_cpol(cpol), .i_cpha(cpha),
    .i_serial_in(ser_in), .i_tx_write(tx_wr), .i_tx_data(tx_d), .i_rx_read(rx_rd),
    .i_status_read(st_rd), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_status(status), .o_serial_out(ser_out),
    .o_spi_clk(spi_clk), .o_irq(irq));
  comm_far_end comm_far_end_i (.i_core_clk(i_core_clk), .i_spi(fn == FN_SPI_MASTER),
    .i_cpol(cpol), .i_cpha(cpha), .i_sclk(spi_clk), .i_mosi(ser_out), .o_line(ser_in));

  // sclk edge counter, for the edge count check of a two-byte transfer
  always @(posedge i_core_clk) begin
    sclk_q <= spi_clk;
    tog <= tog + int'(spi_clk !== sclk_q);
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic wr_tx(input logic [7:0] d);
    tx_d = d;
    tx_wr = 1'b1;
    cyc(1);
    tx_wr = 1'b0;
  endtask
  task automatic rd_status();
    st_rd = 1'b1;
    cyc(1);
    st_rd = 1'b0;
  endtask
  // waits for the head byte, compares with the model, pops it
  task automatic get_rx();
    logic [7:0] e;
    e = rxq.pop_front();
    for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++) cyc(1);
    check("rx_valid", rx_valid, 8'h01);
    check("rx_data", rx_data, e);
    rx_rd = 1'b1;
    cyc(1);
    rx_rd = 1'b0;
  endtask
  // samples a frame at mid-bit, late start tolerated by half a bit
  task automatic cap_tx(input logic [7:0] d);
    for (int n = 0; n < 2000 && ser_out !== 1'b0; n++) cyc(1);
    cyc(BIT_CYC / 2);
    check("start", ser_out, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cyc(BIT_CYC);
      check("data_bit", ser_out, d[i]);
    end
    if (par_en) begin
      cyc(BIT_CYC);
      check("parity", ser_out, ^d ^ par_odd);
    end
    cyc(BIT_CYC);
    check("stop", ser_out, 8'h01);
  endtask
  // interrupt source: empty first, then complete; status read drops complete
  task automatic irq_src();
    check("irq_empty", irq, 8'h01);
    int_sel = 1'b1;
    cyc(2);
    check("irq_done", irq, 8'h01);
    rd_status();
    check("done_clr", status[ST_COMPLETE], 8'h00);
    check("empty_kept", status[ST_TX_EMPTY], 8'h01);
    cyc(1);
    check("irq_quiet", irq, 8'h00);
    int_sel = 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // about 7000 cycles needed; a hang past this counts as a mismatch
  initial begin
    repeat (30000) @(posedge i_core_clk);
    miscompares++;
    conclude();
  end

  initial begin
    seed = 32'h4E2B;
    tog = 0;
    cyc(20);
    i_rst = 1'b0;
    en = 1'b1;
    cyc(2);
    check("rst_status", status, 8'h00);
    check("idle_line", ser_out, 8'h01);
    check("irq_first", irq, 8'h00);
    // every parity setting, two bytes back to back
    for (int p = 0; p < 3; p++) begin
      par_en = (p != 0);
      par_odd = (p == 2);
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr_tx(a);
      for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) cyc(1);
      check("empty_load", status[ST_TX_EMPTY], 8'h01);
      wr_tx(b);
      check("empty_wr", status[ST_TX_EMPTY], 8'h00);
      cap_tx(a);
      cap_tx(b);
    end
    cyc(BIT_CYC / 2 + 3);
    irq_src();
    // receiver: even, odd, bad parity, then a missing stop bit
    fn = FN_UART_RX;
    par_en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      par_odd = (k == 1);
      a = 8'($random(seed));
      comm_far_end_i.uart_send(a, ^a ^ par_odd ^ (k == 2), 1'b1, BIT_CYC);
      rxq.push_back(a);
      check("irq_full", irq, 8'h01);
      check("parity_err", status[ST_PARITY_ERR], k == 2);
      rd_status();
      check("full_kept", status[ST_RX_FULL], 8'h01);
      check("err_clr", status[ST_PARITY_ERR], 8'h00);
      get_rx();
      check("full_clr", rx_valid, 8'h00);
      cyc(1);
      check("irq_drop", irq, 8'h00);
    end
    comm_far_end_i.uart_send(8'h5A, 1'b0, 1'b0, BIT_CYC);
    cyc(BIT_CYC * 12);
    check("framing", status[ST_FRAMING_ERR], 8'h01);
    // reset in mid-run drops any stray byte from the broken frame
    fn = FN_SPI_MASTER;
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = m[1:0];
      en = 1'b0;
      cyc(4);
      en = 1'b1;
      cyc(2);
      a = 8'($random(seed));
      b = 8'($random(seed));
      r = 8'($random(seed));
      comm_far_end_i.spi_load(r);
      t0 = tog;
      wr_tx(a);
      for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) cyc(1);
      wr_tx(b);
      rxq.push_back(r);
      rxq.push_back(~r);
      get_rx();
      get_rx();
      cyc(8);
      check("mosi", comm_far_end_i.seen_q, b);
      check("sclk_edges", 8'(tog - t0), 8'h20);
      check("sclk_idle", spi_clk, cpol);
    end
    irq_src();
    conclude();
  end
endmodule
